// [core/dss_bcd_counter.sv]
// Five-digit BCD cycle counter that wraps from 39,999 to zero.
`timescale 1ns/10ps
`default_nettype none

module dss_bcd_counter
	import dss_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        inc,
	output logic      [17:0] count
);

	`include "dss_defines.svh"

	dss_cnt_t   s_q;
	dss_cnt_t   s_d;
	logic [4:0] carry;
	logic [3:0] nxt [0:3];
	logic [1:0] top_nxt;

	// ==================================================================
	// Decade chain
	assign carry[0] = inc;

	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : g_dec
			wire logic [3:0] cur = s_q.count[g*4 +: 4];
			assign carry[g+1] = carry[g] && (cur == 4'h9);
			assign nxt[g] = !carry[g] ? cur :
				(cur == 4'h9) ? 4'h0 : cur + 4'h1;
		end
	endgenerate

	// The top digit only reaches 3, so 39,999 rolls over to zero.
	assign top_nxt = carry[4] ? s_q.count[17:16] + 2'h1 : s_q.count[17:16];

	// ==================================================================
	// State update
	always_comb begin
		s_d = s_q;
		s_d.count = {top_nxt, nxt[3], nxt[2], nxt[1], nxt[0]};
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q.count <= `DSS_CNT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign count = s_q.count;

endmodule // dss_bcd_counter

`default_nettype wire

// [core/dss_defines.svh]
// Offsets, field positions, reset values and counts of the dual-slope sequencer.
`ifndef DSS_DEFINES_SVH
`define DSS_DEFINES_SVH

// ==========================================================================
// Register offsets
`define DSS_ADDR_CTRL     8'h00
`define DSS_ADDR_STATUS   8'h04
`define DSS_ADDR_RESULT   8'h08
`define DSS_ADDR_COUNT    8'h0C

// ==========================================================================
// Control register fields and reset value
`define DSS_CTRL_FORCE    0
`define DSS_CTRL_BLANK    1
`define DSS_CTRL_RST      2'h0

// ==========================================================================
// Status register fields
`define DSS_ST_HOLD       0
`define DSS_ST_AZ         1
`define DSS_ST_INP        2
`define DSS_ST_REF        3
`define DSS_ST_OVR        4
`define DSS_ST_NEG        5
`define DSS_ST_DONE       6

// ==========================================================================
// Cycle counter marks, packed BCD with a two-bit top digit
`define DSS_CNT_RST       18'h00000
`define DSS_CNT_HOLD      18'h20000
`define DSS_CNT_INPUT     18'h30000
`define DSS_CNT_LAST      18'h39999
`define DSS_CNT_OVR       18'h20000

// ==========================================================================
// Oscillator clock counts and the most significant digit index
`define DSS_HOLD_POLL_LAST 12'hF9F
`define DSS_DIGIT_LAST     9'h18F
`define DSS_DIGIT_MSD      3'h4

`endif

// [core/dss_digit_mux.sv]
// Multiplexed digit scan with overrange blanking.
`timescale 1ns/10ps
`default_nettype none

module dss_digit_mux
	import dss_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic [16:0] result,
	input  wire logic        neg,
	input  wire logic        ovr,
	input  wire logic        blank,
	output logic      [4:0]  digit_en,
	output logic      [3:0]  bcd,
	output logic      [6:0]  seg
);

	`include "dss_defines.svh"

	dss_mux_t s_q;
	dss_mux_t s_d;

	// ==================================================================
	// Segment decode, segments a..g in bits 6..0, high means lit
	function automatic logic [6:0] seg_of(input logic [3:0] v);
		case (v)
			4'h0: seg_of = 7'h7E;
			4'h1: seg_of = 7'h30;
			4'h2: seg_of = 7'h6D;
			4'h3: seg_of = 7'h79;
			4'h4: seg_of = 7'h33;
			4'h5: seg_of = 7'h5B;
			4'h6: seg_of = 7'h5F;
			4'h7: seg_of = 7'h70;
			4'h8: seg_of = 7'h7F;
			4'h9: seg_of = 7'h7B;
			default: seg_of = 7'h00;
		endcase
	endfunction

	// ==================================================================
	// Scan
	always_comb begin
		logic [2:0] nidx;
		logic [3:0] dig;
		nidx = s_q.idx;
		dig = 4'h0;
		s_d = s_q;
		s_d.pre = s_q.pre + 9'h001;
		if (s_q.pre == `DSS_DIGIT_LAST) begin
			s_d.pre = 9'h000;
			nidx = (s_q.idx == `DSS_DIGIT_MSD) ? 3'h0 : s_q.idx + 3'h1;
		end
		s_d.idx = nidx;
		s_d.digit_en = blank ? 5'h00 : 5'h01 << nidx;
		if (nidx == `DSS_DIGIT_MSD) begin
			// Sign and leading one: + 1010, +1 1110, - 1011, -1 1111.
			s_d.bcd = {1'b1, result[16], 1'b1, neg};
			s_d.seg = result[16] ? seg_of(4'h1) : 7'h00;
		end else if (ovr) begin
			s_d.bcd = 4'hF;
			s_d.seg = 7'h00;
		end else begin
			dig = result[nidx[1:0]*4 +: 4];
			s_d.bcd = dig;
			s_d.seg = seg_of(dig);
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	assign digit_en = s_q.digit_en;
	assign bcd = s_q.bcd;
	assign seg = s_q.seg;

endmodule // dss_digit_mux

`default_nettype wire

// [core/dss_pkg.sv]
// Types shared by the dual-slope sequencer modules.
`default_nettype none

package dss_pkg;

	// ==================================================================
	// Phases of one measurement cycle
	typedef enum logic [1:0] {
		DSS_AZ,
		DSS_HOLD,
		DSS_INP,
		DSS_REF
	} dss_phase_t;

	// ==================================================================
	// State records
	typedef struct packed {
		logic [17:0] count;
	} dss_cnt_t;

	typedef struct packed {
		logic [8:0] pre;
		logic [2:0] idx;
		logic [4:0] digit_en;
		logic [3:0] bcd;
		logic [6:0] seg;
	} dss_mux_t;

	typedef struct packed {
		dss_phase_t  phase;
		logic        tick;
		logic        resumed;
		logic [11:0] poll;
		logic        neg;
		logic        ovr;
		logic [16:0] result;
		logic        res_neg;
		logic        res_ovr;
		logic        done;
		logic [1:0]  ctrl;
		logic        ctl_one;
		logic        ctl_two;
		logic [31:0] rdata;
	} dss_seq_t;

endpackage

`default_nettype wire

// [core/dss_sequencer.sv]
// Dual-slope converter sequencer: phase control, result latch, register port.
`timescale 1ns/10ps
`default_nettype none

module dss_sequencer
	import dss_pkg::*;
(
	input  wire logic        mclk,
	input  wire logic        rst,
	input  wire logic        trigger,
	input  wire logic        comp,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             ctl_sel_one,
	output logic             ctl_sel_two,
	output logic             overrange,
	output logic      [4:0]  digit_en,
	output logic      [3:0]  digit_bcd,
	output logic      [6:0]  digit_seg
);

	`include "dss_defines.svh"

	dss_seq_t    s_q;
	dss_seq_t    s_d;
	logic [17:0] count;
	logic        inc;
	logic        trig_hi;
	logic        crossing;
	logic        conv_end;

	// ==================================================================
	// Cycle counter
	// Counting stops only in hold; the count itself never reloads, so the
	// auto-zero phase simply carries on from wherever reference ended.
	assign inc = s_q.tick && (s_q.phase != DSS_HOLD);

	dss_bcd_counter u_counter (
		.mclk  (mclk),
		.rst   (rst),
		.inc   (inc),
		.count (count)
	);

	// ==================================================================
	// Decodes
	// Software may force free running when the trigger pin is not wired.
	assign trig_hi = trigger || s_q.ctrl[`DSS_CTRL_FORCE];

	// The comparator starts reference at the sampled polarity and flips
	// when the integrator passes back through zero, whatever the sign.
	assign crossing = (s_q.phase == DSS_REF) && (comp != !s_q.neg);

	function automatic logic [31:0] status_word(input dss_seq_t s);
		status_word = 32'h0000_0000;
		status_word[`DSS_ST_HOLD] = (s.phase == DSS_HOLD);
		status_word[`DSS_ST_AZ] = (s.phase == DSS_AZ);
		status_word[`DSS_ST_INP] = (s.phase == DSS_INP);
		status_word[`DSS_ST_REF] = (s.phase == DSS_REF);
		status_word[`DSS_ST_OVR] = s.res_ovr;
		status_word[`DSS_ST_NEG] = s.res_neg;
		status_word[`DSS_ST_DONE] = s.done;
	endfunction

	// ==================================================================
	// Phase sequencing
	always_comb begin
		s_d = s_q;
		conv_end = 1'b0;
		s_d.tick = !s_q.tick;
		s_d.poll = 12'h000;

		case (s_q.phase)
			DSS_AZ: begin
				if (count == `DSS_CNT_HOLD && !s_q.resumed) begin
					if (!trig_hi) begin
						s_d.phase = DSS_HOLD;
					end else begin
						s_d.resumed = 1'b1;
					end
				end else if (count == `DSS_CNT_INPUT) begin
					s_d.phase = DSS_INP;
					s_d.resumed = 1'b0;
				end
			end
			DSS_HOLD: begin
				s_d.poll = s_q.poll + 12'h001;
				if (s_q.poll == `DSS_HOLD_POLL_LAST) begin
					s_d.poll = 12'h000;
					if (trig_hi) begin
						s_d.phase = DSS_AZ;
						s_d.resumed = 1'b1;
					end
				end
			end
			DSS_INP: begin
				// 30,000 to 39,999 is exactly 10,000 counts.
				if (inc && count == `DSS_CNT_LAST) begin
					s_d.phase = DSS_REF;
					s_d.neg = !comp;
					s_d.ovr = 1'b0;
				end
			end
			DSS_REF: begin
				if (crossing) begin
					s_d.phase = DSS_AZ;
					conv_end = 1'b1;
				end else if (count == `DSS_CNT_OVR) begin
					s_d.phase = DSS_AZ;
					s_d.ovr = 1'b1;
					conv_end = 1'b1;
				end
			end
			default: begin
				s_d.phase = DSS_AZ;
			end
		endcase

		// ==============================================================
		// Result buffer
		if (conv_end) begin
			s_d.result = s_d.ovr ? 17'h10000 : count[16:0];
			s_d.res_neg = s_q.neg;
			s_d.res_ovr = s_d.ovr;
		end

		// ==============================================================
		// Control lines, registered from the next phase
		case (s_d.phase)
			DSS_INP: begin
				s_d.ctl_one = 1'b1;
				s_d.ctl_two = 1'b1;
			end
			DSS_REF: begin
				s_d.ctl_one = !s_d.neg;
				s_d.ctl_two = s_d.neg;
			end
			DSS_HOLD: begin
				s_d.ctl_one = 1'b0;
				s_d.ctl_two = 1'b0;
			end
			default: begin
				s_d.ctl_one = 1'b0;
				s_d.ctl_two = 1'b0;
			end
		endcase

		// ==============================================================
		// Register port
		if (reg_wr && reg_addr == `DSS_ADDR_CTRL) begin
			s_d.ctrl = reg_wdata[1:0];
		end
		// A new result in the same cycle as the clear keeps the flag set.
		if (reg_wr && reg_addr == `DSS_ADDR_STATUS &&
			reg_wdata[`DSS_ST_DONE]) begin
			s_d.done = 1'b0;
		end
		if (conv_end) begin
			s_d.done = 1'b1;
		end

		s_d.rdata = 32'h0000_0000;
		if (reg_rd) begin
			case (reg_addr)
				`DSS_ADDR_CTRL:   s_d.rdata = {30'h0, s_q.ctrl};
				`DSS_ADDR_STATUS: s_d.rdata = status_word(s_q);
				`DSS_ADDR_RESULT: s_d.rdata = {15'h0, s_q.result};
				`DSS_ADDR_COUNT:  s_d.rdata = {14'h0, count};
				default:          s_d.rdata = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			s_q <= '0;
			s_q.phase <= DSS_AZ;
			s_q.ctrl <= `DSS_CTRL_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ==================================================================
	// Display
	dss_digit_mux u_mux (
		.mclk     (mclk),
		.rst      (rst),
		.result   (s_q.result),
		.neg      (s_q.res_neg),
		.ovr      (s_q.res_ovr),
		.blank    (s_q.ctrl[`DSS_CTRL_BLANK]),
		.digit_en (digit_en),
		.bcd      (digit_bcd),
		.seg      (digit_seg)
	);

	assign reg_rdata = s_q.rdata;
	assign ctl_sel_one = s_q.ctl_one;
	assign ctl_sel_two = s_q.ctl_two;
	assign overrange = s_q.res_ovr;

endmodule // dss_sequencer

`default_nettype wire

// [test/dss_front_model.sv]
// Behavioural analog front end: integrator and zero-crossing comparator.
`timescale 1ns/10ps
`default_nettype none

module dss_front_model #(
	parameter int VIN  = 1,
	parameter int VREF = 200
) (
	input  wire logic mclk,
	input  wire logic rst,
	input  wire logic ctl_sel_one,
	input  wire logic ctl_sel_two,
	output logic      comp
);
	int acc;

	// Auto-zero makes the comparator oscillate, so a sequencer that
	// looks at it there sees no stable level.
	always @(posedge mclk) begin
		if (rst || (!ctl_sel_one && !ctl_sel_two)) begin
			acc  <= 0;
			comp <= rst ? 1'b0 : !comp;
		end else begin
			if (ctl_sel_one && ctl_sel_two)
				acc <= acc + VIN;
			else if (ctl_sel_one)
				acc <= acc - VREF;
			else
				acc <= acc + VREF;
			comp <= (acc > 0);
		end
	end
endmodule // dss_front_model

`default_nettype wire

// [test/dss_sequencer_assertions.sv]
// Port-level checks of the dual-slope sequencer.
`timescale 1ns/10ps
`default_nettype none

module dss_sequencer_assertions (
	input wire logic        mclk,
	input wire logic        rst,
	input wire logic        comp,
	input wire logic        ctl_sel_one,
	input wire logic        ctl_sel_two,
	input wire logic        overrange,
	input wire logic [4:0]  digit_en,
	input wire logic [6:0]  digit_seg
);
	int         inp_q;
	int         gap_q;
	logic [4:0] den_q;
	logic       seen_q;

	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (rst);

	// ==============================================================
	// Helpers
	// The scan rate is judged only after one full step between lit
	// digits, so a blanked stretch never shortens the measured gap.
	always_ff @(posedge mclk) begin
		if (rst) begin
			inp_q  <= 0;
			gap_q  <= 0;
			den_q  <= 5'h00;
			seen_q <= 1'b0;
		end else begin
			inp_q <= (ctl_sel_one && ctl_sel_two) ? inp_q + 1 : 0;
			den_q <= digit_en;
			gap_q <= (digit_en != den_q) ? 0 : gap_q + 1;
			if (digit_en == 5'h00)
				seen_q <= 1'b0;
			else if (digit_en != den_q && den_q != 5'h00)
				seen_q <= 1'b1;
		end
	end

	// ==============================================================
	// Properties
	az_to_input_a: assert property (
		$rose(ctl_sel_one && ctl_sel_two)
		|-> $past(!ctl_sel_one && !ctl_sel_two))
		else $error("Input phase not entered from auto-zero.");
	input_exit_a: assert property (
		(ctl_sel_one && ctl_sel_two) ##1 !(ctl_sel_one && ctl_sel_two)
		|-> ctl_sel_one != ctl_sel_two)
		else $error("Input phase not followed by reference.");
	ref_exit_a: assert property (
		(ctl_sel_one != ctl_sel_two) ##1 (ctl_sel_one == ctl_sel_two)
		|-> !ctl_sel_one && !ctl_sel_two)
		else $error("Reference phase not followed by auto-zero.");
	ref_sign_a: assert property (
		(ctl_sel_one && ctl_sel_two) ##1 (ctl_sel_one != ctl_sel_two)
		|-> ctl_sel_one == $past(comp))
		else $error("Reference polarity does not follow comparator.");
	input_len_a: assert property (
		$fell(ctl_sel_one && ctl_sel_two)
		|-> inp_q >= 19999 && inp_q <= 20001)
		else $error("Input phase length wrong.");
	digit_hot_a: assert property (
		$onehot0(digit_en))
		else $error("More than one digit enabled.");
	digit_rate_a: assert property (
		(digit_en != den_q && den_q != 5'h00 && digit_en != 5'h00 && seen_q)
		|-> gap_q == 399)
		else $error("Digit scan step wrong.");
	ovr_blank_a: assert property (
		(overrange [*3] ##0 (digit_en[3:0] != 4'h0))
		|-> digit_seg == 7'h00)
		else $error("Low digit lit during overrange.");
endmodule // dss_sequencer_assertions

`default_nettype wire

// [test/tb_top.sv]
// Self-checking bench of the dual-slope sequencer with a front end.
`timescale 1ns/10ps
`default_nettype none
`include "dss_defines.svh"

module tb_top;
	typedef struct packed {
		logic        wr;
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic [31:0] exp;
	} dss_row_t;

	logic        mclk;
	logic        rst;
	logic        trigger;
	logic        comp;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        ctl_sel_one;
	logic        ctl_sel_two;
	logic        overrange;
	logic [4:0]  digit_en;
	logic [3:0]  digit_bcd;
	logic [6:0]  digit_seg;
	int          num_errors;
	int          n_checks;
	int          t;
	logic [31:0] rd;
	dss_row_t    rows [6];

	dss_sequencer dss_sequencer_inst (.mclk(mclk), .rst(rst),
		.trigger(trigger), .comp(comp), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.reg_rdata(reg_rdata), .ctl_sel_one(ctl_sel_one),
		.ctl_sel_two(ctl_sel_two), .overrange(overrange),
		.digit_en(digit_en), .digit_bcd(digit_bcd),
		.digit_seg(digit_seg));
	dss_front_model dss_front_model_inst (.mclk(mclk), .rst(rst),
		.ctl_sel_one(ctl_sel_one), .ctl_sel_two(ctl_sel_two),
		.comp(comp));

	// ==============================================================
	// Tasks
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic finish_test;
		$display("errors %0d checks %0d", num_errors, n_checks);
		if (num_errors == 0 && n_checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr  <= a;
		reg_wdata <= d;
		reg_wr    <= 1'b1;
		@(posedge mclk);
		reg_wr    <= 1'b0;
		@(posedge mclk);
	endtask

	task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
		reg_addr <= a;
		reg_rd   <= 1'b1;
		@(posedge mclk);
		reg_rd   <= 1'b0;
		#1;
		d = reg_rdata;
		@(posedge mclk);
	endtask

	// Polling costs two cycles a read, which bounds the timing error.
	task automatic poll(input int b, input logic v, output int n);
		logic [31:0] s;
		n = 0;
		s = {32{~v}};
		while (s[b] !== v && n < 90000) begin
			bus_rd(`DSS_ADDR_STATUS, s);
			n += 2;
		end
	endtask

	task automatic wait_ctl(input logic [1:0] v, output int n);
		n = 0;
		#1;
		while ({ctl_sel_one, ctl_sel_two} !== v && n < 30000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		@(posedge mclk);
	endtask

	task automatic step(output int n);
		logic [4:0] d;
		// The edge spent after the previous change already belongs here.
		n = 1;
		#1;
		d = digit_en;
		while (digit_en === d && n < 1000) begin
			@(posedge mclk);
			#1;
			n++;
		end
		@(posedge mclk);
	endtask

	// ==============================================================
	// Clock and watchdog
	initial begin
		mclk = 1'b0;
		forever #25 mclk = ~mclk;
	end

	initial begin
		repeat (99000) @(posedge mclk);
		num_errors++;
		finish_test();
	end

	// ==============================================================
	// Main sequence
	initial begin
		rst        = 1'b1;
		trigger    = 1'b0;
		reg_addr   = 8'h00;
		reg_wdata  = 32'h0;
		reg_wr     = 1'b0;
		reg_rd     = 1'b0;
		num_errors = 0;
		n_checks   = 0;
		rows = '{'{1'b0, `DSS_ADDR_CTRL, 32'h0, 32'h0},
			'{1'b0, `DSS_ADDR_STATUS, 32'h0, 32'h2},
			'{1'b0, `DSS_ADDR_RESULT, 32'h0, 32'h0},
			'{1'b1, 8'h10, 32'hFFFFFFFF, 32'h0},
			'{1'b1, `DSS_ADDR_CTRL, 32'h3, 32'h3},
			'{1'b1, `DSS_ADDR_CTRL, 32'h2, 32'h2}};
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		foreach (rows[i]) begin
			if (rows[i].wr)
				bus_wr(rows[i].addr, rows[i].wdata);
			bus_rd(rows[i].addr, rd);
			check(rd, rows[i].exp);
		end
		check({27'h0, digit_en}, 32'h0);
		bus_wr(`DSS_ADDR_CTRL, 32'h0);
		step(t);
		step(t);
		step(t);
		check(t, 400);
		for (int i = 0; i < 5 && digit_en !== 5'h10; i++)
			step(t);
		check({28'h0, digit_bcd}, 32'hA);
		check({25'h0, digit_seg}, 32'h0);
		step(t);
		check({27'h0, digit_en}, 32'h1);
		check({25'h0, digit_seg}, 32'h7E);
		poll(`DSS_ST_HOLD, 1'b1, t);
		check({30'h0, ctl_sel_one, ctl_sel_two}, 32'h0);
		bus_rd(`DSS_ADDR_COUNT, rd);
		check(rd, 32'h20000);
		repeat (1000) @(posedge mclk);
		bus_rd(`DSS_ADDR_COUNT, rd);
		check(rd, 32'h20000);
		trigger <= 1'b1;
		poll(`DSS_ST_HOLD, 1'b0, t);
		check({31'h0, t >= 2900 && t <= 3100}, 32'h1);
		wait_ctl(2'b11, t);
		check({31'h0, t >= 19990 && t <= 20002}, 32'h1);
		wait_ctl(2'b10, t);
		check({31'h0, t >= 19997 && t <= 20001}, 32'h1);
		bus_rd(`DSS_ADDR_COUNT, rd);
		check({31'h0, rd <= 32'h2}, 32'h1);
		bus_rd(`DSS_ADDR_STATUS, rd);
		check({29'h0, rd[3:1]}, 32'h4);
		wait_ctl(2'b00, t);
		check({31'h0, t < 400}, 32'h1);
		bus_rd(`DSS_ADDR_RESULT, rd);
		check({31'h0, rd >= 32'h48 && rd <= 32'h58}, 32'h1);
		bus_rd(`DSS_ADDR_STATUS, rd);
		check({29'h0, rd[6:4]}, 32'h4);
		check({31'h0, overrange}, 32'h0);
		rst <= 1'b1;
		repeat (2) @(posedge mclk);
		rst <= 1'b0;
		@(posedge mclk);
		check({30'h0, ctl_sel_one, ctl_sel_two}, 32'h0);
		check({31'h0, overrange}, 32'h0);
		bus_rd(`DSS_ADDR_STATUS, rd);
		check(rd, 32'h2);
		bus_rd(`DSS_ADDR_RESULT, rd);
		check(rd, 32'h0);
		finish_test();
	end
endmodule // tb_top

bind dss_sequencer dss_sequencer_assertions dss_sequencer_assertions_inst (
	.mclk(mclk), .rst(rst), .comp(comp), .ctl_sel_one(ctl_sel_one),
	.ctl_sel_two(ctl_sel_two), .overrange(overrange),
	.digit_en(digit_en), .digit_seg(digit_seg));

`default_nettype wire
